// ==== src/xcac_ctrl.sv ====
// Routes external data moves to on-chip ram, can window or external bus
// Assumes an APB master on pclk and a core issuing move requests synchronous to pclk
//
// The APB register port was chosen for this implementation.
`default_nettype none
`include "xcac_defs.svh"
module xcac_ctrl (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire xcac_pkg::xcac_req_t move_req,
    output xcac_pkg::xcac_route_t    route,
    output logic      [7:0]          onchip_rdata,
    output logic                     port_drive
);
    import xcac_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Control register
    logic [7:0]  system_control_q;
    logic [7:0]  system_control_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        pslverr_q;
    logic        pslverr_d;
    logic        wr_en;
    logic        rd_en;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        setup;
    logic [5:0]  route_q;
    logic [5:0]  route_d;

    // Read data and error load in setup so they stand through the access phase
    assign setup    = psel && !penable;
    assign wr_en    = psel && penable && pwrite;
    assign rd_en    = setup && !pwrite;
    assign hit_ctrl = (paddr == `XCAC_SYSTEM_CONTROL_ADDR);
    assign hit_stat = (paddr == `XCAC_STATUS_ADDR);
    assign pready   = 1'b1;
    assign pslverr  = pslverr_q;
    assign prdata   = prdata_q;

    always_comb begin
        system_control_d  = system_control_q;
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        if (wr_en && hit_ctrl) begin
            system_control_d = pwdata[7:0];
            // Disable bit may only be cleared by software
            system_control_d[`XCAC_BIT_DISABLE] = system_control_q[`XCAC_BIT_DISABLE]
                                        & pwdata[`XCAC_BIT_DISABLE];
        end
        if (rd_en) begin
            if (hit_ctrl) begin
                prdata_d = {24'h00_0000, system_control_q};
            end else if (hit_stat) begin
                prdata_d = {16'h0000, route_q, 10'h000};
            end else begin
                prdata_d = 32'h0000_0000;
            end
        end
        if (setup && !hit_ctrl && !hit_stat) begin
            pslverr_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_control_q  <= `XCAC_SYSTEM_CONTROL_RESET;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            system_control_q  <= system_control_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Routing decision
    logic        dis;
    logic        vis;
    logic        in_range;
    logic        internal;

    assign dis      = system_control_q[`XCAC_BIT_DISABLE];
    assign vis      = system_control_q[`XCAC_BIT_VISIBLE];
    assign in_range = (move_req.addr >= `XCAC_RANGE_LOW)
                   && (move_req.addr <= `XCAC_RANGE_HIGH);
    assign internal = move_req.valid && in_range && !dis;

    always_comb begin
        route_d = 6'b00_0000;
        if (move_req.valid) begin
            route_d[5] = internal;
            route_d[4] = internal && (move_req.addr >= `XCAC_ONCHIP_EXTENDED_RAM_BASE);
            route_d[3] = internal && (move_req.addr < `XCAC_ONCHIP_EXTENDED_RAM_BASE);
            route_d[2] = !internal;
            // Strobes only mirror internal traffic when visible
            route_d[1] = !move_req.write && (!internal || vis);
            route_d[0] = move_req.write && (!internal || vis);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_q <= 6'b00_0000;
        end else begin
            route_q <= route_d;
        end
    end

    assign route      = route_q;
    assign port_drive = route_q[2] || route_q[1] || route_q[0];

    ////////////////////////////////////////////////////////////////////////////
    // On-chip storage
    localparam int ONCHIP_EXTENDED_RAM_WORDS = 2048;
    localparam int CAN_WORDS  = 256;
    logic [7:0]  onchip_extended_ram_mem [ONCHIP_EXTENDED_RAM_WORDS];
    logic [7:0]  can_mem  [CAN_WORDS];
    logic [7:0]  rdata_q;
    logic [15:0] xoff;
    logic [15:0] coff;

    assign xoff = move_req.addr - `XCAC_ONCHIP_EXTENDED_RAM_BASE;
    assign coff = move_req.addr - `XCAC_CAN_BASE;

    always_ff @(posedge pclk) begin
        if (internal && move_req.write) begin
            if (move_req.addr >= `XCAC_ONCHIP_EXTENDED_RAM_BASE) begin
                onchip_extended_ram_mem[xoff[10:0]] <= move_req.wdata;
            end else begin
                can_mem[coff[7:0]] <= move_req.wdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 8'h00;
        end else if (internal && !move_req.write) begin
            rdata_q <= (move_req.addr >= `XCAC_ONCHIP_EXTENDED_RAM_BASE) ? onchip_extended_ram_mem[xoff[10:0]]
                                                          : can_mem[coff[7:0]];
        end
    end

    assign onchip_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // Control register checks
    a_disable_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(system_control_q[0])
        |-> !system_control_q[0])
        else $error("Disable bit set again");

    a_reset_disable: assert property (@(posedge pclk)
        $rose(presetn)
        |-> system_control_q[0])
        else $error("Disable bit not set by reset");

    a_disable_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_ctrl && !pwdata[0])
        |=> !dis)
        else $error("Disable bit not cleared");

    a_visible_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_ctrl)
        |=> (vis == $past(pwdata[1])))
        else $error("Visible bit not written");

    a_system_control_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_en && hit_ctrl)
        |=> $stable(system_control_q))
        else $error("Control register changed without write");

    // Register bus checks
    a_ready_high: assert property (@(posedge pclk) disable iff (!presetn)
        psel
        |-> pready)
        else $error("Ready low");

    a_read_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_en && hit_ctrl)
        |=> (prdata[7:0] == $past(system_control_q)))
        else $error("Control read data wrong");

    a_read_status: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_en && hit_stat)
        |=> (prdata[15:10] == $past(route_q)))
        else $error("Status read data wrong");

    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !hit_ctrl && !hit_stat)
        |=> pslverr)
        else $error("No error on unmapped access");

    a_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && (hit_ctrl || hit_stat))
        |=> !pslverr)
        else $error("Error on mapped access");

    // Routing checks
    a_disabled_ext: assert property (@(posedge pclk) disable iff (!presetn)
        (move_req.valid && dis)
        |=> (route_q[2] && !route_q[5]))
        else $error("Move not external while disabled");

    a_in_range_int: assert property (@(posedge pclk) disable iff (!presetn)
        (move_req.valid && !dis && move_req.addr >= 16'hF700)
        |=> route_q[5])
        else $error("In-range move not internal");

    a_can_sel: assert property (@(posedge pclk) disable iff (!presetn)
        (move_req.valid && !dis && move_req.addr >= 16'hF700 && move_req.addr < 16'hF800)
        |=> (route_q[3] && !route_q[4]))
        else $error("Can window not selected");

    a_onchip_extended_ram_sel: assert property (@(posedge pclk) disable iff (!presetn)
        (move_req.valid && !dis && move_req.addr >= 16'hF800)
        |=> (route_q[4] && !route_q[3]))
        else $error("On-chip ram not selected");

    a_onchip_extended_ram_split: assert property (@(posedge pclk) disable iff (!presetn)
        route_q[5]
        |-> (route_q[4] != route_q[3]))
        else $error("Bad internal select");

    a_ext_no_onchip: assert property (@(posedge pclk) disable iff (!presetn)
        route_q[2]
        |-> !(route_q[5] || route_q[4] || route_q[3]))
        else $error("External and internal at once");

    a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !move_req.valid
        |=> (route_q == 6'b00_0000))
        else $error("Route active without move");

    // Strobe checks
    a_below_ext: assert property (@(posedge pclk) disable iff (!presetn)
        (move_req.valid && move_req.addr < 16'hF700)
        |=> (route_q[2] && (route_q[1] || route_q[0])))
        else $error("Low address not on bus");

    a_ext_strobe: assert property (@(posedge pclk) disable iff (!presetn)
        (move_req.valid && !internal)
        |=> (route_q[0] == $past(move_req.write) && route_q[1] == !$past(move_req.write)))
        else $error("External strobe wrong");

    a_one_strobe: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1
        |-> !(route_q[1] && route_q[0]))
        else $error("Both strobes active");

    a_hidden_strobe: assert property (@(posedge pclk) disable iff (!presetn)
        (move_req.valid && !dis && !vis && move_req.addr >= 16'hF700)
        |=> !(route_q[1] || route_q[0] || port_drive))
        else $error("Strobe during hidden access");

    a_visible_strobe: assert property (@(posedge pclk) disable iff (!presetn)
        (move_req.valid && !dis && vis && move_req.addr >= 16'hF700)
        |=> (port_drive && (route_q[1] || route_q[0])))
        else $error("No strobe during visible access");

    // Main scenarios
    c_internal: cover property (@(posedge pclk) disable iff (!presetn) route_q[5]);
    c_visible: cover property (@(posedge pclk) disable iff (!presetn) route_q[5] && port_drive);
    c_can_access: cover property (@(posedge pclk) disable iff (!presetn) route_q[3]);
    c_ext_write: cover property (@(posedge pclk) disable iff (!presetn) route_q[2] && route_q[0]);
    c_refused_set: cover property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_ctrl && pwdata[0] && !dis);
endmodule // xcac_ctrl
`default_nettype wire

// ==== src/xcac_defs.svh ====
// Offsets, field positions, reset values and range limits for onchip_extended_ram/can access control
// Assumes inclusion by the design file and the bench
`ifndef XCAC_DEFS_SVH
`define XCAC_DEFS_SVH
`define XCAC_SYSTEM_CONTROL_INDEX    8'hB1
`define XCAC_SYSTEM_CONTROL_ADDR     12'h2C4
`define XCAC_STATUS_ADDR     12'h000
`define XCAC_BIT_DISABLE     0
`define XCAC_BIT_VISIBLE     1
`define XCAC_SYSTEM_CONTROL_RESET    8'h01
`define XCAC_RANGE_LOW       16'hF700
`define XCAC_RANGE_HIGH      16'hFFFF
`define XCAC_CAN_BASE        16'hF700
`define XCAC_ONCHIP_EXTENDED_RAM_BASE       16'hF800
`endif

// ==== src/xcac_pkg.sv ====
// Types for onchip_extended_ram/can access control
// Assumes the defs header beside it
`default_nettype none
package xcac_pkg;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } xcac_req_t;
    typedef struct packed {
        logic onchip_sel;
        logic onchip_extended_ram_sel;
        logic can_sel;
        logic ext_bus;
        logic rd_strobe;
        logic wr_strobe;
    } xcac_route_t;
endpackage
`default_nettype wire

// ==== tb/tb_top.sv ====
// Bench for the move router: APB register access and routed moves
// Assumes the core model beside it and the defs header on the path
`default_nettype none
`include "xcac_defs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import xcac_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, port_drive, err;
    logic [7:0]  onchip_rdata;
    xcac_req_t   move_req;
    xcac_route_t route;
    int          n_mismatch = 0, comparisons = 0, cyc = 0;
    logic [15:0] tbl [6] = '{16'h0000, 16'hF6FF, 16'hF700, 16'hF7FF, 16'hF800, 16'hFFFF};
    xcac_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .move_req(move_req), .route(route),
        .onchip_rdata(onchip_rdata), .port_drive(port_drive));
    xcac_core_model core (.pclk(pclk), .move_req(move_req));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic mv(input logic dis, vis, w, input logic [15:0] a);
        logic i_r, x_r, s_r;
        i_r = a >= `XCAC_RANGE_LOW && !dis;
        x_r = i_r && a >= `XCAC_ONCHIP_EXTENDED_RAM_BASE;
        s_r = !i_r || vis;
        core.issue(w, a, a[7:0] ^ 8'hC3);
        #1 chk({25'h0, route, port_drive}, {25'h0, i_r, x_r, i_r && !x_r, !i_r,
            s_r && !w, s_r && w, s_r});
        if (i_r && !w)
            chk({24'h0, onchip_rdata}, {24'h0, a[7:0] ^ 8'hC3});
    endtask
    task automatic phase(input logic dis, vis);
        for (int w = 1; w >= 0; w--)
            foreach (tbl[i])
                mv(dis, vis, w[0], tbl[i]);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `XCAC_SYSTEM_CONTROL_ADDR, '0);
        chk(rd, 32'h0000_0001);
        phase(1'b0 + 1'b1, 1'b0);
        apb(1'b1, `XCAC_SYSTEM_CONTROL_ADDR, 32'h0000_0003);
        apb(1'b0, `XCAC_SYSTEM_CONTROL_ADDR, '0);
        chk(rd, 32'h0000_0003);
        phase(1'b1, 1'b1);
        apb(1'b1, `XCAC_SYSTEM_CONTROL_ADDR, '0);
        phase(1'b0, 1'b0);
        apb(1'b1, `XCAC_SYSTEM_CONTROL_ADDR, 32'h0000_0003);
        apb(1'b0, `XCAC_SYSTEM_CONTROL_ADDR, '0);
        chk(rd, 32'h0000_0002);
        phase(1'b0, 1'b1);
        apb(1'b1, 12'h010, 32'h0000_0001);
        chk({31'h0, err}, 32'h0000_0001);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `XCAC_SYSTEM_CONTROL_ADDR, '0);
        chk(rd, 32'h0000_0001);
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire

// ==== tb/xcac_core_model.sv ====
// Core model issuing external data moves
// Assumes it shares pclk with the block
`default_nettype none
module xcac_core_model (
    input  wire logic                pclk,
    output var xcac_pkg::xcac_req_t  move_req
);
    timeunit 1ns;
    timeprecision 1ns;
    import xcac_pkg::*;
    initial move_req = '0;
    // One move a call; fields scrambled once released
    task automatic issue(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge pclk);
        move_req <= '{1'b1, w, a, d};
        @(posedge pclk);
        move_req <= '{1'b0, 1'b0, ~a, ~d};
    endtask
endmodule // xcac_core_model
`default_nettype wire
